// ---- logic/sleep_ctl_consts.svh ----
// offsets, field positions, encodings and timing counts of the sleep controller
`ifndef SLEEP_CTL_CONSTS_SVH
`define SLEEP_CTL_CONSTS_SVH

// ==========================================
// register indices, byte address = index * 4
`define MCU_CTRL_INDEX      10'h035
`define IRQ_MASK_INDEX      10'h020
`define SLEEP_STATUS_INDEX  10'h021
`define APB_ADDR_W          12

// ==========================================
// control register fields
`define CTRL_PUD_BIT        6
`define CTRL_SLEEP_ALLOW    5
`define CTRL_MODE_HI        4
`define CTRL_MODE_LO        3
`define CTRL_SENSE_HI       1
`define CTRL_SENSE_LO       0
`define CTRL_WRITE_MASK     8'h7b
`define CTRL_RESET          8'h00

// ==========================================
// mask register fields
`define MASK_EXT_EN_BIT     6
`define MASK_WRITE_MASK     8'h40
`define MASK_RESET          8'h00

// ==========================================
// status register fields
`define STAT_STATE_LO       0
`define STAT_EDGE_FLAG      2
`define STAT_SKIPPED        3
`define STAT_PIN_LEVEL      4
`define STAT_RESET_WAKE     5

// ==========================================
// sleep modes and sense encodings
`define MODE_IDLE           2'h0
`define MODE_NOISE          2'h1
`define MODE_PDOWN          2'h2
`define MODE_STANDBY        2'h3
`define SENSE_LOW           2'h0
`define SENSE_ANY           2'h1
`define SENSE_FALL          2'h2
`define SENSE_RISE          2'h3

// ==========================================
// timing
`define SYS_CLK_PERIOD_NS   25
`define WDT_OSC_PERIOD_NS   1000
`define WDT_TICK_CYCLES     (`WDT_OSC_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`define WAKE_HALT_CYCLES    4
`define STANDBY_WAKE_CYCLES 6
`define RESTART_DLY_0       64
`define RESTART_DLY_1       256
`define RESTART_DLY_2       1024
`define RESTART_DLY_3       16384

`endif

// ---- logic/sleep_ctl_pkg.sv ----
// types shared by the sleep controller files
package sleep_ctl_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_RESTART, ST_HALT} sleep_state_t;
	typedef logic [1:0] sleep_mode_t;
endpackage : sleep_ctl_pkg

// ---- logic/pin_sync.sv ----
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_pinOut;

	always_comb begin
		next_stage1 = pinIn;
		next_pinOut = stage1;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			pinOut <= '0;
		end else begin
			stage1 <= next_stage1;
			pinOut <= next_pinOut;
		end
	end
endmodule : pin_sync

// ---- logic/wake_sampler.sv ----
// double sampling of wake levels on watchdog oscillator ticks
`timescale 1ns/1ps
module wake_sampler #(
	parameter int W = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         armed,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] confirmed
);
	logic [W-1:0] firstSeen;
	logic [W-1:0] next_firstSeen;
	logic [W-1:0] next_confirmed;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// both consecutive samples must show the level
			always_comb begin
				next_firstSeen[i] = firstSeen[i];
				next_confirmed[i] = confirmed[i];
				if (!armed) begin
					next_firstSeen[i] = 1'b0;
					next_confirmed[i] = 1'b0;
				end else if (tick) begin
					next_firstSeen[i] = level[i];
					next_confirmed[i] = level[i] & firstSeen[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			firstSeen <= '0;
			confirmed <= '0;
		end else begin
			firstSeen <= next_firstSeen;
			confirmed <= next_confirmed;
		end
	end
endmodule : wake_sampler

// ---- logic/sleep_mode_and_ext_irq_sense.sv ----
// sleep-mode controller with external interrupt sense and apb registers
//
// Contract
// - sense 00 low, 01 change, 10 fall, 11 rise
// - request needs global flag and own enable
// - sleep only when sleep-allow bit set
// - halt four cycles after start-up on wake
// - register file and ram kept across sleep
// - reset during sleep wakes to reset vector
// - idle stops only cpu and flash clocks
// - idle wakes on external and internal interrupts
// - idle or noise mode starts enabled adc
// - noise mode stops io, cpu, flash clocks
// - noise mode wake sources limited to listed
// - power-down stops oscillator and all clocks
// - power-down wake sources limited to listed
// - power-down wake waits fuse-chosen restart delay
// - level wake needs two watchdog samples; idle and noise wake on the level directly
// - vanished wake condition skips its interrupt
// - standby keeps oscillator, wakes in six cycles
// - clock domains gated per mode table
// - deep modes: level only; nvm, adc shallow only
// - mode bits 4:3, allow 5, sense 1:0
`include "sleep_ctl_consts.svh"
`timescale 1ns/1ps
module sleep_mode_and_ext_irq_sense #(
	parameter int RESTART_DLY0 = `RESTART_DLY_0,
	parameter int RESTART_DLY1 = `RESTART_DLY_1,
	parameter int RESTART_DLY2 = `RESTART_DLY_2,
	parameter int RESTART_DLY3 = `RESTART_DLY_3
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   sleepInstr,
	input  wire logic                   globalIrqEnable,
	input  wire logic                   extIrqAck,
	input  wire logic                   extIrqPin,
	input  wire logic                   extResetPin,
	input  wire logic                   pinChangeIrq,
	input  wire logic                   usiStartIrq,
	input  wire logic                   nvmReadyIrq,
	input  wire logic                   adcDoneIrq,
	input  wire logic                   otherIoIrq,
	input  wire logic                   wdtResetReq,
	input  wire logic                   brownOutReq,
	input  wire logic                   adcEnabled,
	input  wire logic                   crystalSelected,
	input  wire logic [3:0]             clockSourceFuses,
	output logic                        cpuClkEn,
	output logic                        flashClkEn,
	output logic                        ioClkEn,
	output logic                        adcClkEn,
	output logic                        mainOscEn,
	output logic                        extIrqRequest,
	output logic                        adcStartConv,
	output logic                        resumeFromReset,
	output logic                        pullUpDisable
);
	// ==========================================
	// helpers
	// {io clock, adc clock, main oscillator} kept while asleep
	function automatic logic [2:0] sleepGating(input sleep_ctl_pkg::sleep_mode_t m);
		unique case (m)
			`MODE_IDLE:    sleepGating = 3'h7;
			`MODE_NOISE:   sleepGating = 3'h3;
			`MODE_PDOWN:   sleepGating = 3'h0;
			`MODE_STANDBY: sleepGating = 3'h1;
		endcase
	endfunction : sleepGating

	function automatic logic isAddr(input logic [`APB_ADDR_W-1:0] a, input logic [9:0] idx);
		isAddr = (a == {idx, 2'b00});
	endfunction : isAddr

	// ==========================================
	// pin synchronisers
	logic extPinSync;
	logic extResetSync;

	pin_sync #(
		.W (2)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pinIn   ({extResetPin, extIrqPin}),
		.pinOut  ({extResetSync, extPinSync})
	);

	// ==========================================
	// apb register slave
	logic [7:0] ctrlReg;
	logic [7:0] maskReg;
	logic [7:0] next_ctrlReg;
	logic [7:0] next_maskReg;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [7:0]  statusReg;
	logic        wrStrobe;
	logic        hitCtrl;
	logic        hitMask;
	logic        hitStatus;

	assign wrStrobe  = psel & penable & pready & pwrite;
	assign hitCtrl   = isAddr(paddr, `MCU_CTRL_INDEX);
	assign hitMask   = isAddr(paddr, `IRQ_MASK_INDEX);
	assign hitStatus = isAddr(paddr, `SLEEP_STATUS_INDEX);

	always_comb begin
		next_ctrlReg = ctrlReg;
		next_maskReg = maskReg;
		next_prdata  = prdata;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		// reserved bits stay zero
		if (wrStrobe && hitCtrl)
			next_ctrlReg = pwdata[7:0] & `CTRL_WRITE_MASK;
		if (wrStrobe && hitMask)
			next_maskReg = pwdata[7:0] & `MASK_WRITE_MASK;
		// answer in the first access cycle
		if (psel && !penable) begin
			next_pready  = 1'b1;
			next_pslverr = !(hitCtrl || hitMask || hitStatus);
			if (pwrite)
				next_prdata = 32'h0000_0000;
			else if (hitCtrl)
				next_prdata = {24'h00_0000, ctrlReg};
			else if (hitMask)
				next_prdata = {24'h00_0000, maskReg};
			else if (hitStatus)
				next_prdata = {24'h00_0000, statusReg};
			else
				next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlReg <= `CTRL_RESET;
			maskReg <= `MASK_RESET;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrlReg <= next_ctrlReg;
			maskReg <= next_maskReg;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================
	// control fields
	logic                      sleepAllow;
	sleep_ctl_pkg::sleep_mode_t modeSel;
	logic [1:0]                senseSel;
	logic                      extEnable;

	assign sleepAllow = ctrlReg[`CTRL_SLEEP_ALLOW];
	assign modeSel    = ctrlReg[`CTRL_MODE_HI:`CTRL_MODE_LO];
	assign senseSel   = ctrlReg[`CTRL_SENSE_HI:`CTRL_SENSE_LO];
	assign extEnable  = maskReg[`MASK_EXT_EN_BIT];

	// ==========================================
	// external interrupt sense
	logic prevPin;
	logic edgeFlag;
	logic next_prevPin;
	logic next_edgeFlag;
	logic next_extIrqRequest;
	logic edgeHit;
	logic levelLow;
	logic extPending;

	always_comb begin
		unique case (senseSel)
			`SENSE_ANY:  edgeHit = extPinSync ^ prevPin;
			`SENSE_FALL: edgeHit = prevPin & ~extPinSync;
			`SENSE_RISE: edgeHit = extPinSync & ~prevPin;
			`SENSE_LOW:  edgeHit = 1'b0;
		endcase
	end

	assign levelLow   = (senseSel == `SENSE_LOW) & ~extPinSync;
	assign extPending = levelLow | edgeFlag;

	logic running;

	always_comb begin
		next_prevPin  = extPinSync;
		next_edgeFlag = edgeFlag;
		// a new edge wins over the acknowledge
		if (extIrqAck)
			next_edgeFlag = 1'b0;
		if (edgeHit)
			next_edgeFlag = 1'b1;
		if (senseSel == `SENSE_LOW)
			next_edgeFlag = 1'b0;
		next_extIrqRequest = running & globalIrqEnable & extEnable & extPending;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prevPin       <= 1'b1;
			edgeFlag      <= 1'b0;
			extIrqRequest <= 1'b0;
		end else begin
			prevPin       <= next_prevPin;
			edgeFlag      <= next_edgeFlag;
			extIrqRequest <= next_extIrqRequest;
		end
	end

	// ==========================================
	// watchdog oscillator tick divider
	logic [15:0] wdtDiv;
	logic [15:0] next_wdtDiv;
	logic        wdtTick;
	logic        next_wdtTick;

	always_comb begin
		next_wdtTick = 1'b0;
		next_wdtDiv  = wdtDiv + 16'h0001;
		if (wdtDiv == 16'(`WDT_TICK_CYCLES - 1)) begin
			next_wdtDiv  = 16'h0000;
			next_wdtTick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdtDiv  <= 16'h0000;
			wdtTick <= 1'b0;
		end else begin
			wdtDiv  <= next_wdtDiv;
			wdtTick <= next_wdtTick;
		end
	end

	// ==========================================
	// level confirmation in deep sleep
	sleep_ctl_pkg::sleep_state_t state;
	sleep_ctl_pkg::sleep_mode_t  effMode;
	logic                        deepSleep;
	logic [1:0]                  levelConfirmed;

	assign deepSleep = (state == sleep_ctl_pkg::ST_SLEEP) &&
		(effMode == `MODE_PDOWN || effMode == `MODE_STANDBY);

	wake_sampler #(
		.W (2)
	) u_wake_sampler (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.tick      (wdtTick),
		.armed     (deepSleep),
		.level     ({pinChangeIrq, extEnable & levelLow}),
		.confirmed (levelConfirmed)
	);

	// ==========================================
	// wake source selection
	logic extLevelWake;
	logic wakeIrq;
	logic resetReq;

	assign extLevelWake = extEnable & levelLow;
	assign resetReq     = extResetSync | wdtResetReq | brownOutReq;

	always_comb begin
		unique case (effMode)
			`MODE_IDLE:
				wakeIrq = (extEnable & extPending) | pinChangeIrq | usiStartIrq |
					nvmReadyIrq | adcDoneIrq | otherIoIrq;
			`MODE_NOISE:
				wakeIrq = extLevelWake | pinChangeIrq | usiStartIrq | nvmReadyIrq | adcDoneIrq;
			`MODE_PDOWN, `MODE_STANDBY:
				wakeIrq = levelConfirmed[0] | levelConfirmed[1] | usiStartIrq;
		endcase
	end

	// ==========================================
	// sleep state machine and clock gating
	sleep_ctl_pkg::sleep_state_t next_state;
	sleep_ctl_pkg::sleep_mode_t  next_effMode;
	logic [15:0]                 count;
	logic [15:0]                 next_count;
	logic [15:0]                 restartDly;
	logic                        byReset;
	logic                        next_byReset;
	logic                        byExtLevel;
	logic                        next_byExtLevel;
	logic                        skipped;
	logic                        next_skipped;
	logic [2:0]                  keep;
	logic                        next_cpuClkEn;
	logic                        next_flashClkEn;
	logic                        next_ioClkEn;
	logic                        next_adcClkEn;
	logic                        next_mainOscEn;
	logic                        next_adcStartConv;
	logic                        next_resumeFromReset;
	logic                        next_pullUpDisable;

	assign running = (state == sleep_ctl_pkg::ST_RUN);

	always_comb begin
		unique case (clockSourceFuses[1:0])
			2'h0: restartDly = 16'(RESTART_DLY0);
			2'h1: restartDly = 16'(RESTART_DLY1);
			2'h2: restartDly = 16'(RESTART_DLY2);
			2'h3: restartDly = 16'(RESTART_DLY3);
		endcase
	end

	assign keep = sleepGating(effMode);

	always_comb begin
		next_state           = state;
		next_effMode         = effMode;
		next_count           = count;
		next_byReset         = byReset;
		next_byExtLevel      = byExtLevel;
		next_skipped         = skipped;
		next_adcStartConv    = 1'b0;
		next_resumeFromReset = 1'b0;
		next_pullUpDisable   = ctrlReg[`CTRL_PUD_BIT];
		unique case (state)
			sleep_ctl_pkg::ST_RUN: begin
				if (sleepInstr && sleepAllow) begin
					next_state   = sleep_ctl_pkg::ST_SLEEP;
					next_byReset = 1'b0;
					next_skipped = 1'b0;
					// standby without a crystal falls back to power-down
					next_effMode = (modeSel == `MODE_STANDBY && !crystalSelected) ? `MODE_PDOWN : modeSel;
					next_adcStartConv = adcEnabled &&
						(modeSel == `MODE_IDLE || modeSel == `MODE_NOISE);
				end
			end
			sleep_ctl_pkg::ST_SLEEP: begin
				if (resetReq || wakeIrq) begin
					next_byReset    = resetReq;
					next_byExtLevel = !resetReq && extLevelWake;
					unique case (effMode)
						`MODE_PDOWN: begin
							next_state = sleep_ctl_pkg::ST_RESTART;
							next_count = restartDly;
						end
						`MODE_STANDBY: begin
							next_state = sleep_ctl_pkg::ST_RESTART;
							next_count = 16'(`STANDBY_WAKE_CYCLES - `WAKE_HALT_CYCLES);
						end
						`MODE_IDLE, `MODE_NOISE: begin
							next_state = sleep_ctl_pkg::ST_HALT;
							next_count = 16'(`WAKE_HALT_CYCLES);
						end
					endcase
				end
			end
			sleep_ctl_pkg::ST_RESTART: begin
				next_count = count - 16'h0001;
				if (count <= 16'h0001) begin
					next_state = sleep_ctl_pkg::ST_HALT;
					next_count = 16'(`WAKE_HALT_CYCLES);
				end
			end
			sleep_ctl_pkg::ST_HALT: begin
				next_count = count - 16'h0001;
				if (count <= 16'h0001) begin
					// core state untouched, only the restart point differs
					next_state           = sleep_ctl_pkg::ST_RUN;
					next_resumeFromReset = byReset;
					next_skipped         = byExtLevel && !levelLow;
				end
			end
		endcase
		// power-down keeps no clock at all, standby keeps clock of nothing but the oscillator
		next_cpuClkEn   = (next_state == sleep_ctl_pkg::ST_RUN);
		next_flashClkEn = (next_state == sleep_ctl_pkg::ST_RUN) ||
			(next_state == sleep_ctl_pkg::ST_HALT);
		next_ioClkEn    = next_flashClkEn;
		next_adcClkEn   = next_flashClkEn;
		next_mainOscEn  = 1'b1;
		if (next_state == sleep_ctl_pkg::ST_SLEEP) begin
			next_ioClkEn   = keep[2];
			next_adcClkEn  = keep[1];
			next_mainOscEn = keep[0];
		end else if (next_state == sleep_ctl_pkg::ST_RESTART) begin
			next_ioClkEn   = 1'b0;
			next_adcClkEn  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state           <= sleep_ctl_pkg::ST_RUN;
			effMode         <= `MODE_IDLE;
			count           <= 16'h0000;
			byReset         <= 1'b0;
			byExtLevel      <= 1'b0;
			skipped         <= 1'b0;
			cpuClkEn        <= 1'b1;
			flashClkEn      <= 1'b1;
			ioClkEn         <= 1'b1;
			adcClkEn        <= 1'b1;
			mainOscEn       <= 1'b1;
			adcStartConv    <= 1'b0;
			resumeFromReset <= 1'b0;
			pullUpDisable   <= 1'b0;
		end else begin
			state           <= next_state;
			effMode         <= next_effMode;
			count           <= next_count;
			byReset         <= next_byReset;
			byExtLevel      <= next_byExtLevel;
			skipped         <= next_skipped;
			cpuClkEn        <= next_cpuClkEn;
			flashClkEn      <= next_flashClkEn;
			ioClkEn         <= next_ioClkEn;
			adcClkEn        <= next_adcClkEn;
			mainOscEn       <= next_mainOscEn;
			adcStartConv    <= next_adcStartConv;
			resumeFromReset <= next_resumeFromReset;
			pullUpDisable   <= next_pullUpDisable;
		end
	end

	// ==========================================
	// status view
	always_comb begin
		statusReg                                       = 8'h00;
		statusReg[`STAT_STATE_LO+1:`STAT_STATE_LO]     = 2'(state);
		statusReg[`STAT_EDGE_FLAG]                      = edgeFlag;
		statusReg[`STAT_SKIPPED]                        = skipped;
		statusReg[`STAT_PIN_LEVEL]                      = extPinSync;
		statusReg[`STAT_RESET_WAKE]                     = byReset;
	end
endmodule : sleep_mode_and_ext_irq_sense

// ---- tb/core_partner.sv ----
// core model that takes external interrupt requests and acknowledges them
`timescale 1ns/1ps
module core_partner (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       extIrqRequest,
	output logic            extIrqAck,
	output logic [7:0]      taken
);
	// ==========================================
	// one-cycle ack per taken request, then a gap
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			extIrqAck <= 1'b0;
			taken     <= 8'h00;
		end else begin
			extIrqAck <= extIrqRequest && !extIrqAck;
			taken     <= taken + {7'h00, extIrqRequest && !extIrqAck};
		end
	end
endmodule : core_partner

// ---- tb/sleep_ctl_props.sv ----
// concurrent checks on the sleep controller ports
`timescale 1ns/1ps
module sleep_ctl_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleepInstr,
	input wire logic globalIrqEnable,
	input wire logic adcEnabled,
	input wire logic cpuClkEn,
	input wire logic flashClkEn,
	input wire logic ioClkEn,
	input wire logic adcClkEn,
	input wire logic mainOscEn,
	input wire logic extIrqRequest,
	input wire logic adcStartConv,
	input wire logic resumeFromReset
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// ==========================================
	// bus and clock relations
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_flash_before_cpu: assert property (!flashClkEn |-> !cpuClkEn)
		else $error("cpu clock runs without flash clock");
	a_osc_off_all: assert property (!mainOscEn |-> !(cpuClkEn || flashClkEn || ioClkEn || adcClkEn))
		else $error("clock runs with oscillator stopped");
	a_halt_four: assert property ($rose(flashClkEn) && !cpuClkEn |-> !cpuClkEn [*4] ##1 cpuClkEn)
		else $error("halt length wrong");
	a_adc_start_cause: assert property (adcStartConv |-> adcClkEn && !cpuClkEn && $past(sleepInstr) && $past(adcEnabled))
		else $error("adc start without sleep entry");
	a_request_gated: assert property (extIrqRequest |-> $past(globalIrqEnable))
		else $error("request without global flag");
	a_reset_resume: assert property (resumeFromReset |-> cpuClkEn)
		else $error("reset resume while halted");

	cover property (adcStartConv);
	cover property ($rose(cpuClkEn));
	cover property (pslverr);
endmodule : sleep_ctl_props

// ---- tb/test_sleep_mode_and_ext_irq_sense.sv ----
// bench for the sleep controller: registers, sense codes, sleep modes, wake paths
`include "sleep_ctl_consts.svh"
`timescale 1ns/1ps
module test_sleep_mode_and_ext_irq_sense;
	localparam logic [11:0] CTRL = {`MCU_CTRL_INDEX, 2'h0};
	localparam logic [11:0] MASK = {`IRQ_MASK_INDEX, 2'h0};
	localparam logic [11:0] STAT = {`SLEEP_STATUS_INDEX, 2'h0};
	localparam int DLY = 8;
	logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h00017dc2;
	logic sleepInstr = 1'b0, globalIrqEnable = 1'b0, extIrqAck, extIrqPin = 1'b1, wdtResetReq = 1'b0;
	logic extResetPin = 1'b0, brownOutReq = 1'b0, adcEnabled = 1'b1, crystalSelected = 1'b1, sawReset = 1'b0;
	logic [3:0] clockSourceFuses = 4'h0;
	logic [4:0] src = 5'h00;
	logic cpuClkEn, flashClkEn, ioClkEn, adcClkEn, mainOscEn, extIrqRequest, adcStartConv, resumeFromReset;
	logic pullUpDisable;
	logic [7:0] taken, t0;
	int failures = 0, num_checks = 0, n;

	sleep_mode_and_ext_irq_sense #(.RESTART_DLY0(DLY), .RESTART_DLY1(DLY + 4), .RESTART_DLY2(DLY + 8),
		.RESTART_DLY3(DLY + 12)) dut (
		.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepInstr,
		.globalIrqEnable, .extIrqAck, .extIrqPin, .extResetPin, .pinChangeIrq(src[4]), .usiStartIrq(src[3]),
		.nvmReadyIrq(src[2]), .adcDoneIrq(src[1]), .otherIoIrq(src[0]), .wdtResetReq, .brownOutReq, .adcEnabled,
		.crystalSelected, .clockSourceFuses, .cpuClkEn, .flashClkEn, .ioClkEn, .adcClkEn, .mainOscEn,
		.extIrqRequest, .adcStartConv, .resumeFromReset, .pullUpDisable);
	core_partner core (.sys_clk, .rst, .extIrqRequest, .extIrqAck, .taken);

	initial forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (resumeFromReset === 1'b1) sawReset <= 1'b1;

	// ==========================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// {cpu, flash, io, adc, osc}
	function automatic logic [4:0] clk_exp(input logic [1:0] m);
		case (m)
			`MODE_IDLE: return 5'h07;
			`MODE_NOISE: return 5'h03;
			`MODE_STANDBY: return 5'h01;
			default: return 5'h00;
		endcase
	endfunction : clk_exp
	// {pin change, serial start, nvm, adc, other}; pin change too short to be confirmed
	function automatic logic [4:0] bad_src(input logic [1:0] m);
		case (m)
			`MODE_IDLE: return 5'h00;
			`MODE_NOISE: return 5'h01;
			default: return 5'h17;
		endcase
	endfunction : bad_src
	function automatic logic [4:0] good_src(input logic [1:0] m);
		case (m)
			`MODE_IDLE: return 5'h01;
			`MODE_NOISE: return 5'h02;
			default: return 5'h08;
		endcase
	endfunction : good_src
	function automatic int wake_min(input logic [1:0] m);
		case (m)
			`MODE_PDOWN: return DLY + 4 * clockSourceFuses[1:0] + `WAKE_HALT_CYCLES;
			`MODE_STANDBY: return `STANDBY_WAKE_CYCLES;
			default: return `WAKE_HALT_CYCLES;
		endcase
	endfunction : wake_min
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
			output logic err);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k == 16) begin
			failures++;
			$display("MISMATCH %0t apb answer timed out", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse_sleep;
		@(posedge sys_clk);
		sleepInstr <= 1'b1;
		@(posedge sys_clk);
		sleepInstr <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : pulse_sleep
	task automatic wait_cpu;
		n = 0;
		while (cpuClkEn !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
	endtask : wait_cpu
	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		clockSourceFuses <= seed[3:0];
		repeat (3) @(posedge sys_clk);
		apb(1'b0, CTRL, 32'h0, q, e);
		chk(q, 32'h0, "ctrl reset");
		apb(1'b0, 12'h0f0, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1, "unmapped");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			apb(1'b1, CTRL, seed, q, e);
			apb(1'b0, CTRL, 32'h0, q, e);
			chk(q, seed & `CTRL_WRITE_MASK, "ctrl bits");
			chk(pullUpDisable, seed[6], "pull-up");
		end
		apb(1'b1, MASK, 32'hffffffff, q, e);
		apb(1'b0, MASK, 32'h0, q, e);
		chk(q, 32'h40, "mask bits");
		apb(1'b1, MASK, 32'h0, q, e);
		apb(1'b1, CTRL, 32'h10, q, e);
		pulse_sleep;
		chk(cpuClkEn, 1'b1, "sleep without allow");
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, CTRL, 32'h20 | (m << 3), q, e);
			pulse_sleep;
			chk({cpuClkEn, flashClkEn, ioClkEn, adcClkEn, mainOscEn}, clk_exp(m[1:0]), "gating");
			src <= bad_src(m[1:0]);
			repeat (30) @(posedge sys_clk);
			src <= 5'h00;
			repeat (3) @(posedge sys_clk);
			chk(cpuClkEn, 1'b0, "stray wake");
			src <= good_src(m[1:0]);
			wait_cpu;
			src <= 5'h00;
			chk(n >= wake_min(m[1:0]) && n <= wake_min(m[1:0]) + 4, 1'b1, "wake time");
		end
		apb(1'b1, CTRL, 32'h30, q, e);
		pulse_sleep;
		src <= 5'h10;
		wait_cpu;
		src <= 5'h00;
		chk(cpuClkEn === 1'b1 && n > `WDT_TICK_CYCLES + wake_min(2'h2), 1'b1, "confirmed level wake");
		apb(1'b1, CTRL, 32'h30, q, e);
		pulse_sleep;
		wdtResetReq <= 1'b1;
		wait_cpu;
		wdtResetReq <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(sawReset, 1'b1, "reset wake");
		apb(1'b0, STAT, 32'h0, q, e);
		chk(q & 32'h20, 32'h20, "reset wake status");
		apb(1'b1, MASK, 32'h40, q, e);
		extIrqPin <= 1'b0;
		pulse_sleep;
		wait (mainOscEn === 1'b1);
		@(posedge sys_clk);
		extIrqPin <= 1'b1;
		wait_cpu;
		apb(1'b0, STAT, 32'h0, q, e);
		chk(q & 32'h08, 32'h08, "vanished wake skipped");
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, MASK, 32'h0, q, e);
			apb(1'b1, CTRL, 32'h0, q, e);
			extIrqPin <= ~s[0];
			apb(1'b1, CTRL, s, q, e);
			apb(1'b1, MASK, 32'h40, q, e);
			extIrqPin <= s[0];
			repeat (10) @(posedge sys_clk);
			chk(extIrqRequest, 1'b0, "global flag off");
			t0 = taken;
			globalIrqEnable <= 1'b1;
			repeat (10) @(posedge sys_clk);
			chk(taken != t0, 1'b1, "sense code");
			globalIrqEnable <= 1'b0;
			extIrqPin <= 1'b1;
		end
		print_verdict;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict;
	end
endmodule : test_sleep_mode_and_ext_irq_sense

bind sleep_mode_and_ext_irq_sense sleep_ctl_props chk_i (.sys_clk, .rst, .psel, .penable, .pready, .pslverr,
	.sleepInstr, .globalIrqEnable, .adcEnabled, .cpuClkEn, .flashClkEn, .ioClkEn, .adcClkEn, .mainOscEn,
	.extIrqRequest, .adcStartConv, .resumeFromReset);
